// ==== shared/dacs_pkg.sv ====
package dacs_pkg;

  // ---------------------------------------------------------------
  // Widths and bit counting
  // ---------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int WORD_W = 16;
  localparam int MEM_DEPTH = 32;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_ACKCLK = 4'h9;

  // ---------------------------------------------------------------
  // Byte codes
  // ---------------------------------------------------------------
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_RESET = 8'h06;
  localparam logic [7:0] GC_WAKE = 8'h0A;
  localparam logic [1:0] CC_WRITE = 2'h0;
  localparam logic [1:0] CC_READ = 2'h3;

  // ---------------------------------------------------------------
  // Memory map and reset values
  // ---------------------------------------------------------------
  localparam logic [4:0] NV_BASE = 5'h10;
  localparam logic [31:0] IMPL_MAP = 32'hFFFF0703;
  localparam logic [4:0] SLAVE_HI = 5'h18;
  localparam logic [4:0] PTR_RESET = 5'h00;
  localparam logic [15:0] MEM_RESET = 16'h0000;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] data;
  } dacs_upd_s;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_DHI,
    ST_DLO,
    ST_GC,
    ST_RDGO,
    ST_RD,
    ST_ERR
  } dacs_state_e;

endpackage

// ==== src/dacs_slave.sv ====
`timescale 1ns/1ps

// -----------------------------------------------------------------
// Update FIFO
// -----------------------------------------------------------------
module dacs_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data = store[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// Functional notes
// - Code byte not acknowledged, enters high speed
// - High speed accepted, left at Stop
// - Control byte follows code; Restart keeps speed
// - Command bits: 00 write, 11 read
// - All resolutions use 16-bit data word
// - Read: write command, Restart, read 16 bits
// - Write 38 clocks, stream 27n+11, read 48
// - Stream read 18n+11, last 29, calls 20
// - Acknowledge general call address, decode next
// - Decode general call second byte values
// - Start or Stop mid-data aborts command
// - Volatile write commits on final data bit
// - Nonvolatile programming starts only after Stop
// - Write-lock bit blocks volatile writes
// - Five-bit pointer, zero at reset, retained
// - Serial clock is never driven
// - Wake-up general call leaves power-down
module dacs_slave #(
  parameter logic [4:0] SLAVE_ADDR_HI = dacs_pkg::SLAVE_HI,
  parameter logic [31:0] IMPL = dacs_pkg::IMPL_MAP,
  parameter int RESOLUTION = 12,
  parameter int UPD_DEPTH = dacs_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_sel,
  input wire logic high_voltage_select_pin,
  input wire logic [31:0] wr_lock,
  input wire logic nv_busy,
  input wire logic pd_set,
  output logic upd_valid,
  input wire logic upd_ready,
  output dacs_pkg::dacs_upd_s upd_data,
  output logic nv_start,
  output dacs_pkg::dacs_upd_s nv_data,
  output logic hs_mode,
  output logic gc_reset,
  output logic powered_down,
  output logic [4:0] addr_ptr
);
  import dacs_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic hv_m, hv_s;
  logic [1:0] as_m, as_s;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  always_ff @(posedge clock) begin
    if (rst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      hv_m <= 1'b0;
      hv_s <= 1'b0;
      as_m <= 2'h0;
      as_s <= 2'h0;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      hv_m <= high_voltage_select_pin;
      hv_s <= hv_m;
      as_m <= addr_sel;
      as_s <= as_m;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  assign sda_out = 1'b0;

  // ---------------------------------------------------------------
  // Protocol state
  // ---------------------------------------------------------------
  dacs_state_e state;
  logic [3:0] cnt;
  logic [6:0] sr;
  logic [7:0] rx_byte;
  logic [7:0] tx;
  logic [7:0] data_hi;
  logic [4:0] cmd_addr;
  logic ack_ok;
  logic rd_hi;
  logic nv_pend;
  logic byte_end;
  logic vol_commit;
  logic nv_commit;
  logic is_vol;
  logic fifo_ready;
  logic [15:0] word;
  logic [15:0] mem [MEM_DEPTH];

  assign rx_byte = {sr, sda_s};
  assign byte_end = scl_rise & (cnt == BIT_LAST);
  assign word = {data_hi, rx_byte};
  assign is_vol = (cmd_addr < NV_BASE);
  assign addr_ptr = cmd_addr;

  assign vol_commit = byte_end & (state == ST_DLO) & is_vol
                      & !wr_lock[cmd_addr];
  assign nv_commit = stop_cond & nv_pend & hv_s;

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      sr <= 7'h00;
      tx <= 8'h00;
      data_hi <= 8'h00;
      cmd_addr <= PTR_RESET;
      ack_ok <= 1'b0;
      rd_hi <= 1'b0;
      nv_pend <= 1'b0;
      sda_oe <= 1'b0;
      hs_mode <= 1'b0;
      gc_reset <= 1'b0;
    end else begin
      gc_reset <= 1'b0;
      if (start_cond) begin
        state <= ST_ADDR;
        cnt <= 4'h0;
        sda_oe <= 1'b0;
        nv_pend <= 1'b0;
      end else if (stop_cond) begin
        state <= ST_IDLE;
        cnt <= 4'h0;
        sda_oe <= 1'b0;
        hs_mode <= 1'b0;
        nv_pend <= 1'b0;
      end else if (scl_rise) begin
        if (cnt < BIT_ACK) begin
          sr <= rx_byte[6:0];
          cnt <= cnt + 4'h1;
        end else if (cnt == BIT_ACKCLK && state == ST_RD && sda_s) begin
          state <= ST_ERR;
        end
        if (cnt == BIT_LAST) begin
          ack_ok <= 1'b0;
          unique case (state)
            ST_ADDR: begin
              if (rx_byte == GC_ADDR) begin
                ack_ok <= 1'b1;
                state <= ST_GC;
              end else if (rx_byte[7:3] == HS_CODE_TOP) begin
                hs_mode <= 1'b1;
                state <= ST_ERR;
              end else if (rx_byte[7:1] == {SLAVE_ADDR_HI, as_s}) begin
                ack_ok <= 1'b1;
                if (rx_byte[0]) begin
                  state <= ST_RDGO;
                  tx <= mem[cmd_addr][15:8];
                  rd_hi <= 1'b0;
                end else begin
                  state <= ST_CMD;
                end
              end else begin
                state <= ST_ERR;
              end
            end
            ST_CMD: begin
              cmd_addr <= rx_byte[7:3];
              if (!IMPL[rx_byte[7:3]] || nv_pend) begin
                state <= ST_ERR;
              end else if (rx_byte[2:1] == CC_READ) begin
                ack_ok <= 1'b1;
                state <= ST_ERR;
              end else if (rx_byte[2:1] != CC_WRITE) begin
                state <= ST_ERR;
              end else if (rx_byte[7:3] < NV_BASE) begin
                ack_ok <= fifo_ready;
                state <= fifo_ready ? ST_DHI : ST_ERR;
              end else begin
                ack_ok <= !nv_busy;
                state <= nv_busy ? ST_ERR : ST_DHI;
              end
            end
            ST_DHI: begin
              data_hi <= rx_byte;
              ack_ok <= 1'b1;
              state <= ST_DLO;
            end
            ST_DLO: begin
              ack_ok <= 1'b1;
              state <= ST_CMD;
              if (!is_vol) begin
                nv_pend <= 1'b1;
              end
            end
            ST_GC: begin
              state <= ST_ERR;
              if (rx_byte == GC_RESET) begin
                ack_ok <= 1'b1;
                gc_reset <= 1'b1;
              end else if (rx_byte == GC_WAKE) begin
                ack_ok <= 1'b1;
              end
            end
            ST_RD: begin
              tx <= rd_hi ? mem[cmd_addr][15:8] : mem[cmd_addr][7:0];
              rd_hi <= ~rd_hi;
            end
            default: begin
              state <= ST_ERR;
            end
          endcase
        end
      end else if (scl_fall) begin
        if (cnt == BIT_ACK) begin
          cnt <= BIT_ACKCLK;
          sda_oe <= (state == ST_RD) ? 1'b0 : ack_ok;
        end else if (cnt == BIT_ACKCLK) begin
          cnt <= 4'h0;
          if (state == ST_RDGO || state == ST_RD) begin
            state <= ST_RD;
            sda_oe <= ~tx[7];
          end else begin
            sda_oe <= 1'b0;
          end
        end else if (state == ST_RD) begin
          sda_oe <= ~tx[3'(4'h7 - cnt)];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Memory array and side effects
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= MEM_RESET;
      end
    end else if (vol_commit) begin
      mem[cmd_addr] <= word;
    end else if (nv_commit) begin
      mem[nv_data.addr] <= nv_data.data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      nv_start <= 1'b0;
      nv_data <= '0;
    end else begin
      nv_start <= nv_commit;
      if (byte_end && state == ST_DLO && !is_vol) begin
        nv_data <= '{addr: cmd_addr, data: word};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      powered_down <= 1'b0;
    end else if (byte_end && state == ST_GC && rx_byte == GC_WAKE) begin
      powered_down <= 1'b0;
    end else if (pd_set) begin
      powered_down <= 1'b1;
    end
  end

  dacs_fifo #(
    .WIDTH($bits(dacs_upd_s)),
    .DEPTH(UPD_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(vol_commit),
    .in_ready(fifo_ready),
    .in_data({cmd_addr, word}),
    .out_valid(upd_valid),
    .out_ready(upd_ready),
    .out_data(upd_data)
  );
endmodule

// ==== tb/dacs_monitor.sv ====
`timescale 1ns/1ps
module dacs_monitor
  import dacs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic upd_valid,
  input wire logic upd_ready,
  input wire dacs_pkg::dacs_upd_s upd_data,
  input wire logic nv_start,
  input wire logic hs_mode,
  input wire logic gc_reset,
  input wire logic [4:0] addr_ptr
);
  import dacs_pkg::*;
  logic sp;
  logic stp;
  logic [7:0] ss;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  assign stp = sda_in & ~sp & scl_in;
  always_ff @(posedge clock) begin
    sp <= sda_in;
  end
  // Cycles since a stop on the pins
  always_ff @(posedge clock) begin
    if (rst)
      ss <= 8'hFF;
    else if (stp)
      ss <= 8'h00;
    else if (ss != 8'hFF)
      ss <= ss + 8'h01;
  end
  property p_rst;
    $fell(rst) |-> !hs_mode && !sda_oe && !upd_valid && addr_ptr == 5'h00;
  endproperty
  a_rst: assert property (p_rst)
    else $error("state not cleared by reset");
  property p_hs_off;
    stp |-> ##[1:8] !hs_mode;
  endproperty
  a_hs_off: assert property (p_hs_off)
    else $error("high speed kept after stop");
  property p_hs_nack;
    $rose(hs_mode) |-> !sda_oe [*8] ##1 !sda_oe [*8] ##1 !sda_oe [*8];
  endproperty
  a_hs_nack: assert property (p_hs_nack)
    else $error("code byte acknowledged");
  property p_oe;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  a_oe: assert property (p_oe)
    else $error("data line moved while clock high");
  property p_nv;
    nv_start |-> ss < 8'h10;
  endproperty
  a_nv: assert property (p_nv)
    else $error("programming started without stop");
  property p_upd;
    upd_valid && !upd_ready |=> upd_valid && $stable(upd_data);
  endproperty
  a_upd: assert property (p_upd)
    else $error("update word lost while stalled");
  property p_gc;
    gc_reset |=> !gc_reset;
  endproperty
  a_gc: assert property (p_gc)
    else $error("reset call pulse too long");
  property p_ptr;
    stp |=> $stable(addr_ptr) [*6];
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("pointer changed at stop");
endmodule

bind dacs_slave dacs_monitor mon (.clock, .rst, .scl_in, .sda_in, .sda_oe,
  .upd_valid, .upd_ready, .upd_data, .nv_start, .hs_mode, .gc_reset,
  .addr_ptr);

// ==== tb/dacs_master.sv ====
`timescale 1ns/1ps
module dacs_master (
  output logic scl,
  output wire sda,
  input wire logic sda_oe
);
  logic drv;
  // Open drain with pull-up
  assign sda = drv & ~sda_oe;
  initial begin
    scl = 1'h1;
    drv = 1'h1;
  end
  task start;
    #31 drv = 1'h1;
    #31 scl = 1'h1;
    #62 drv = 1'h0;
    #62 scl = 1'h0;
  endtask
  task stop;
    #31 drv = 1'h0;
    #31 scl = 1'h1;
    #62 drv = 1'h1;
    #62;
  endtask
  task xb(input logic [7:0] v, input logic k, output logic [7:0] r,
    output logic a);
    logic [8:0] w;
    logic [8:0] s;
    w = {v, k};
    for (int i = 8; i >= 0; i--) begin
      #31.25 drv = w[i];
      #31.25 scl = 1'h1;
      #62.5 s[i] = sda;
      scl = 1'h0;
    end
    r = s[8:1];
    a = ~s[0];
  endtask
endmodule

// ==== tb/dacs_slave_test.sv ====
`timescale 1ns/1ps
module dacs_slave_test;
  import dacs_pkg::*;
  logic clock, rst, pd_set, upd_ready, nv_busy, hv, sda_oe, sda_out;
  logic upd_valid, nv_start, hs_mode, gc_reset, powered_down, scl, ak;
  wire sda;
  logic [31:0] wr_lock;
  logic [4:0] addr_ptr;
  logic [7:0] rd;
  logic [15:0] d;
  dacs_upd_s upd_data, nv_data, nvd;
  int miscompares, checks, cc, nvs, gcs;

  dacs_master m (.scl, .sda, .sda_oe);
  dacs_slave dut (.clock, .rst, .scl_in(scl), .sda_in(sda), .sda_out,
    .sda_oe, .addr_sel(2'h0), .high_voltage_select_pin(hv), .wr_lock,
    .nv_busy, .pd_set, .upd_valid, .upd_ready, .upd_data, .nv_start,
    .nv_data, .hs_mode, .gc_reset, .powered_down, .addr_ptr);

  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cc++;
    if (nv_start === 1'h1) begin
      nvs++;
      nvd = nv_data;
    end
    if (gc_reset === 1'h1)
      gcs++;
    if (cc == 40000) begin
      miscompares++;
      finish_test;
    end
  end
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task b(input logic [7:0] v, input logic e);
    m.xb(v, 1'h1, rd, ak);
    chk(ak, e);
  endtask
  task w(input logic [4:0] a, input logic [15:0] v);
    b({a, 3'h0}, 1'h1);
    b(v[15:8], 1'h1);
    b(v[7:0], 1'h1);
  endtask
  task wn(input logic [4:0] a);
    m.xb({a, 3'h0}, 1'h1, rd, ak);
    m.xb(8'h5A, 1'h1, rd, ak);
    b(8'hA5, 1'h0);
  endtask
  task r(input logic [4:0] a, output logic [15:0] v);
    m.start;
    b(8'hC0, 1'h1);
    b({a, 3'h6}, 1'h1);
    m.start;
    b(8'hC1, 1'h1);
    m.xb(8'hFF, 1'h0, v[15:8], ak);
    m.xb(8'hFF, 1'h1, v[7:0], ak);
    m.stop;
  endtask
  initial begin
    {rst, pd_set, upd_ready, nv_busy, hv, wr_lock} = {5'h10, 32'h0};
    cyc(10);
    rst = 1'h0;
    cyc(4);
    chk({hs_mode, powered_down, sda_oe, upd_valid, addr_ptr}, 0);
    chk(sda_out, 1'h0);
    m.start;
    b(8'h0B, 1'h0);
    chk(hs_mode, 1);
    m.start;
    b(8'hC0, 1'h1);
    chk(hs_mode, 1);
    m.stop;
    cyc(4);
    chk(hs_mode, 0);
    $display("test high speed done");
    m.start;
    b(8'hC0, 1'h1);
    w(5'h08, 16'h1234);
    chk({upd_valid, upd_data}, {6'h28, 16'h1234});
    chk(addr_ptr, 5'h08);
    cyc(1);
    upd_ready = 1'h1;
    cyc(1);
    upd_ready = 1'h0;
    wr_lock = 32'h100;
    w(5'h08, 16'h5555);
    chk(upd_valid, 0);
    wr_lock = 32'h0;
    m.stop;
    r(5'h08, d);
    chk(d, 16'h1234);
    chk(addr_ptr, 5'h08);
    d = 16'h0000;
    m.start;
    b(8'hC1, 1'h1);
    m.xb(8'hFF, 1'h0, d[15:8], ak);
    m.xb(8'hFF, 1'h0, d[7:0], ak);
    chk(d, 16'h1234);
    d = 16'h0000;
    m.xb(8'hFF, 1'h0, d[15:8], ak);
    m.xb(8'hFF, 1'h1, d[7:0], ak);
    m.stop;
    chk(d, 16'h1234);
    m.start;
    b(8'hC0, 1'h1);
    b(8'h10, 1'h0);
    b(8'h12, 1'h0);
    m.start;
    b(8'hC0, 1'h1);
    b(8'h02, 1'h0);
    m.start;
    b(8'hC0, 1'h1);
    b(8'h50, 1'h1);
    b(8'h77, 1'h1);
    m.stop;
    cyc(4);
    chk(upd_valid, 0);
    r(5'h0A, d);
    chk(d, 16'h0000);
    $display("test write read done");
    m.start;
    b(8'hC0, 1'h1);
    for (int i = 0; i < 16; i++)
      w(5'h09, i[15:0]);
    wn(5'h09);
    m.stop;
    cyc(1);
    upd_ready = 1'h1;
    for (int i = 0; i < 16; i++) begin
      chk({upd_valid, upd_data}, {6'h29, i[15:0]});
      cyc(1);
    end
    upd_ready = 1'h0;
    chk(upd_valid, 0);
    $display("test buffer done");
    hv = 1'h1;
    m.start;
    b(8'hC0, 1'h1);
    w(5'h10, 16'hABCD);
    cyc(8);
    chk(nvs, 0);
    m.stop;
    cyc(8);
    chk(nvd, {5'h10, 16'hABCD});
    hv = 1'h0;
    nv_busy = 1'h1;
    m.start;
    b(8'hC0, 1'h1);
    wn(5'h10);
    m.stop;
    nv_busy = 1'h0;
    chk(nvs, 1);
    cyc(1);
    pd_set = 1'h1;
    cyc(1);
    pd_set = 1'h0;
    cyc(1);
    chk(powered_down, 1);
    m.start;
    b(8'h00, 1'h1);
    b(8'h0A, 1'h1);
    m.stop;
    cyc(4);
    chk(powered_down, 0);
    m.start;
    b(8'h00, 1'h1);
    b(8'h06, 1'h1);
    m.stop;
    m.start;
    b(8'h00, 1'h1);
    b(8'h00, 1'h0);
    m.stop;
    chk(gcs, 1);
    $display("test general call done");
    finish_test;
  end
endmodule
